// ---- bpe_pkg.sv ----
/*
  Constants, register map and types for the bit-error-rate tester with
  pattern generation and transmit error insertion.
  Assumes one clock (pclk, 25 MHz) and an APB slave with 32-bit data.
*/
package bpe_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [5:0] IDX_CONTROL = 6'h00;
  localparam logic [5:0] IDX_PAT_CFG = 6'h02;
  localparam logic [5:0] IDX_TAP_CFG = 6'h03;
  localparam logic [5:0] IDX_SEED0   = 6'h04;
  localparam logic [5:0] IDX_SEED1   = 6'h05;
  localparam logic [5:0] IDX_SEED2   = 6'h06;
  localparam logic [5:0] IDX_SEED3   = 6'h07;
  localparam logic [5:0] IDX_EIC     = 6'h08;
  localparam logic [5:0] IDX_STATUS  = 6'h0c;
  localparam logic [5:0] IDX_LATCHED = 6'h0e;
  localparam logic [5:0] IDX_COUNT0  = 6'h14;
  localparam logic [5:0] IDX_COUNT1  = 6'h15;
  localparam logic [5:0] IDX_COUNT2  = 6'h16;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_UPDATE_MODE   = 7;
  localparam int CTL_LOCAL_UPDATE  = 6;
  localparam int CTL_RX_LOAD       = 5;
  localparam int CTL_RX_INVERT     = 4;
  localparam int CTL_MAN_RESYNC    = 3;
  localparam int CTL_AUTO_DISABLE  = 2;
  localparam int CTL_TX_LOAD       = 1;
  localparam int CTL_TX_INVERT     = 0;
  localparam int PCFG_REPETITIVE   = 5;
  localparam int EIC_RATE_LSB      = 3;
  localparam int EIC_SINGLE_ENABLE = 2;
  localparam int EIC_SINGLE_REQ    = 1;
  localparam int EIC_MANUAL_SEL    = 0;
  localparam int ST_UPDATE         = 3;
  localparam int ST_BIT_ERROR      = 2;
  localparam int ST_COUNT_NZ       = 1;
  localparam int ST_OOS            = 0;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_RESET = 8'h00;
  localparam logic [31:0] SEED_RESET = 32'h0000_0000;
  localparam logic [7:0]  PCFG_MASK = 8'h3f;
  localparam logic [7:0]  TAP_MASK  = 8'h1f;
  localparam logic [7:0]  EIC_MASK  = 8'h3f;

  // ----------------------------------------------------------------
  // Counts
  // ----------------------------------------------------------------
  localparam logic [23:0] COUNT_MAX     = 24'hff_ffff;
  localparam logic [5:0]  SYNC_MATCHES  = 6'h20;
  localparam logic [2:0]  RESYNC_ERRORS = 3'h6;
  localparam logic [5:0]  WINDOW_LAST   = 6'h3f;

  // Receive sync state
  typedef enum logic [0:0] {
    BPE_RX_HUNT = 1'b0,
    BPE_RX_SYNC = 1'b1
  } bpe_rx_e;

endpackage

// ---- bpe_pattern_gen.sv ----
/*
  Programmable 32-stage pattern generator, used for transmit and receive.
  Assumes the caller holds configuration steady while loading.
*/
`timescale 1ns/1ps
module bpe_pattern_gen
  import bpe_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Configuration
  input  wire logic        load,
  input  wire logic [31:0] seed,
  input  wire logic [4:0]  length_sel,
  input  wire logic [4:0]  tap_sel,
  input  wire logic        repetitive,
  // Stream control
  input  wire logic        advance,
  input  wire logic        hunt,
  input  wire logic        hunt_bit,
  output logic             out_bit
);

  typedef struct packed {
    logic [31:0] stages;
  } bpe_gen_s;

  bpe_gen_s s;
  bpe_gen_s next_s;
  logic     feedback;

  // Output is stage n; stage k sits at index k-1
  assign out_bit = s.stages[length_sel];

  // Feedback: length stage, xor tap stage only for PRBS
  always_comb begin
    next_s   = s;
    feedback = s.stages[length_sel];
    if (!repetitive) begin
      feedback = s.stages[length_sel] ^ s.stages[tap_sel];
    end
    if (load) begin
      next_s.stages = seed;
    end else if (advance) begin
      // While hunting a PRBS the received bit seeds the register
      next_s.stages = {s.stages[30:0], (hunt && !repetitive) ? hunt_bit : feedback};
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule // bpe_pattern_gen

// ---- bpe_bert.sv ----
/*
  Bit-error-rate tester: APB registers, transmit pattern with error
  insertion, receive checker with sync, error count and status.
  Assumes tx_enable, rx_valid and rx_data come from logic on pclk; the
  manual insert and external update inputs are asynchronous pins.
*/
`timescale 1ns/1ps

// Contract
// - PRBS tap feedback comes from stage tap select plus one.
// - Repetitive pattern mode ignores the tap select field.
// - PRBS feedback is length stage xor tap stage.
// - 32-bit seed seeds PRBS or is the repetitive pattern.
// - Transmit sends seed bit 31 first for 32-bit lengths.
// - Receive aligns seed bit 31 with first received bit.
// - Rate n inverts one bit in every ten to the n.
// - Rate zero disables periodic error insertion.
// - Periodic insertion starts on writing a nonzero rate.
// - Rewriting during insertion switches rate after next error.
// - Single-error enable bit gates single insertion.
// - Each request rising edge inverts one bit when selected.
// - Several request edges between opportunities give one error.
// - Manual source select picks request bit or external input.
// - Update status rises when counter update completes.
// - Update status forced low when selected trigger goes low.
// - Count status reads one when reported error count nonzero.
// - Out-of-sync reads one while receiver not synchronised.
// - Latched status bits set on events, clear on read.
// - Length feedback comes from stage length select plus one.
// - 24-bit error counter saturates, holds while out of sync.
// - Six mismatches in a 64-bit window force resync unless disabled.
module bpe_bert
  import bpe_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Transmit stream
  input  wire logic        tx_enable,
  output logic             tx_data,
  // Receive stream
  input  wire logic        rx_valid,
  input  wire logic        rx_data,
  output logic             out_of_sync,
  // External triggers (asynchronous pins)
  input  wire logic        manual_insert_input,
  input  wire logic        external_update_signal
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  control;
    logic [7:0]  pat_cfg;
    logic [7:0]  tap_cfg;
    logic [31:0] seed_pattern;
    logic [7:0]  error_insert_control;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        mi_s1;
    logic        mi_s2;
    logic        eu_s1;
    logic        eu_s2;
    logic        single_trig_d;
    logic        update_trig_d;
    logic        rx_load_d;
    logic        resync_d;
    logic        tx_load_d;
    logic        single_pend;
    logic [2:0]  cur_rate;
    logic [2:0]  new_rate;
    logic        rate_pend;
    logic [23:0] rate_cnt;
    logic        tx_data;
    bpe_rx_e     rx_state;
    logic [5:0]  match_cnt;
    logic [5:0]  win_cnt;
    logic [2:0]  win_err;
    logic [23:0] err_cnt;
    logic [23:0] reported_cnt;
    logic        update_status;
    logic [3:0]  latched;
  } bpe_state_s;

  bpe_state_s s;
  bpe_state_s next_s;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------

  // Period of periodic insertion, ten to the n bits
  function automatic logic [23:0] decade(input logic [2:0] n);
    logic [23:0] r;
    case (n)
      3'h1:    r = 24'h00_000a;
      3'h2:    r = 24'h00_0064;
      3'h3:    r = 24'h00_03e8;
      3'h4:    r = 24'h00_2710;
      3'h5:    r = 24'h01_86a0;
      3'h6:    r = 24'h0f_4240;
      3'h7:    r = 24'h98_9680;
      default: r = 24'h00_0000;
    endcase
    return r;
  endfunction

  // Saturating increment of a 24-bit count
  function automatic logic [23:0] sat_inc(input logic [23:0] v);
    return (v == COUNT_MAX) ? v : 24'(v + 24'h00_0001);
  endfunction

  // ----------------------------------------------------------------
  // Pattern generators
  // ----------------------------------------------------------------
  logic tx_gen_bit;
  logic rx_ref_bit;
  logic tx_load_go;
  logic rx_load_go;
  logic rx_bit;
  logic rx_match;
  logic rx_advance;
  logic rx_hunting;

  assign tx_load_go = s.control[CTL_TX_LOAD] && !s.tx_load_d;
  assign rx_load_go = s.control[CTL_RX_LOAD] && !s.rx_load_d;
  assign rx_bit     = rx_data ^ s.control[CTL_RX_INVERT];
  assign rx_match   = (rx_bit == rx_ref_bit);
  assign rx_hunting = (s.rx_state == BPE_RX_HUNT);
  // A repetitive pattern slips one bit on a mismatch while hunting
  assign rx_advance = rx_valid && !(rx_hunting && s.pat_cfg[PCFG_REPETITIVE] && !rx_match);

  bpe_pattern_gen u_tx_gen (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (tx_load_go),
    .seed       (s.seed_pattern),
    .length_sel (s.pat_cfg[4:0]),
    .tap_sel    (s.tap_cfg[4:0]),
    .repetitive (s.pat_cfg[PCFG_REPETITIVE]),
    .advance    (tx_enable),
    .hunt       (1'b0),
    .hunt_bit   (1'b0),
    .out_bit    (tx_gen_bit)
  );

  bpe_pattern_gen u_rx_gen (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (rx_load_go),
    .seed       (s.seed_pattern),
    .length_sel (s.pat_cfg[4:0]),
    .tap_sel    (s.tap_cfg[4:0]),
    .repetitive (s.pat_cfg[PCFG_REPETITIVE]),
    .advance    (rx_advance),
    .hunt       (rx_hunting),
    .hunt_bit   (rx_bit),
    .out_bit    (rx_ref_bit)
  );

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  logic [5:0]  idx;
  logic        mapped;
  logic        wr_go;
  logic        rd_go;
  logic [7:0]  rd_byte;
  logic        single_trig;
  logic        update_trig;
  logic        rate_hit;
  logic        insert;
  logic        bit_error;
  logic [2:0]  win_sum;
  logic [2:0]  wr_rate;
  logic [3:0]  events;

  always_comb begin
    next_s      = s;
    idx         = paddr[7:2];
    wr_rate     = pwdata[EIC_RATE_LSB +: 3];
    rd_byte     = 8'h00;
    bit_error   = 1'b0;
    win_sum     = 3'h0;
    events      = 4'h0;

    // Two-flop synchronisers for the asynchronous pins
    next_s.mi_s1 = manual_insert_input;
    next_s.mi_s2 = s.mi_s1;
    next_s.eu_s1 = external_update_signal;
    next_s.eu_s2 = s.eu_s1;

    // Edge history of software-driven triggers
    next_s.tx_load_d = s.control[CTL_TX_LOAD];
    next_s.rx_load_d = s.control[CTL_RX_LOAD];
    next_s.resync_d  = s.control[CTL_MAN_RESYNC];

    // Address decode; unmapped words answer with an error
    case (idx)
      IDX_CONTROL: rd_byte = s.control;
      IDX_PAT_CFG: rd_byte = s.pat_cfg;
      IDX_TAP_CFG: rd_byte = s.tap_cfg;
      IDX_SEED0:   rd_byte = s.seed_pattern[7:0];
      IDX_SEED1:   rd_byte = s.seed_pattern[15:8];
      IDX_SEED2:   rd_byte = s.seed_pattern[23:16];
      IDX_SEED3:   rd_byte = s.seed_pattern[31:24];
      IDX_EIC:     rd_byte = s.error_insert_control;
      IDX_STATUS:  rd_byte = {4'h0, s.update_status, 1'b0,
                              (s.reported_cnt != 24'h00_0000),
                              (s.rx_state != BPE_RX_SYNC)};
      IDX_LATCHED: rd_byte = {4'h0, s.latched};
      IDX_COUNT0:  rd_byte = s.reported_cnt[7:0];
      IDX_COUNT1:  rd_byte = s.reported_cnt[15:8];
      IDX_COUNT2:  rd_byte = s.reported_cnt[23:16];
      default:     rd_byte = 8'h00;
    endcase
    mapped = (paddr[1:0] == 2'b00) &&
             (idx == IDX_CONTROL || idx == IDX_PAT_CFG || idx == IDX_TAP_CFG ||
              idx == IDX_SEED0 || idx == IDX_SEED1 || idx == IDX_SEED2 ||
              idx == IDX_SEED3 || idx == IDX_EIC || idx == IDX_STATUS ||
              idx == IDX_LATCHED || idx == IDX_COUNT0 || idx == IDX_COUNT1 ||
              idx == IDX_COUNT2);

    // One wait state: data prepared on the first access edge
    next_s.pready  = psel && penable && !s.pready;
    next_s.prdata  = s.prdata;
    next_s.pslverr = 1'b0;
    if (psel && penable && !s.pready) begin
      next_s.prdata  = {24'h00_0000, rd_byte};
      next_s.pslverr = !mapped;
    end
    wr_go = psel && penable && s.pready && pwrite && mapped;
    rd_go = psel && penable && s.pready && !pwrite && mapped;

    // Transmit: periodic and single error insertion
    single_trig = s.error_insert_control[EIC_MANUAL_SEL] ?
                  s.mi_s2 : s.error_insert_control[EIC_SINGLE_REQ];
    next_s.single_trig_d = single_trig;
    rate_hit = (s.cur_rate != 3'h0) &&
               (s.rate_cnt == 24'(decade(s.cur_rate) - 24'h00_0001));
    insert   = tx_enable && (rate_hit || s.single_pend);
    if (tx_enable) begin
      // Inverted for this bit only; the generator itself runs on
      next_s.tx_data = tx_gen_bit ^ insert ^ s.control[CTL_TX_INVERT];
      if (s.cur_rate != 3'h0) begin
        next_s.rate_cnt = rate_hit ? 24'h00_0000 : 24'(s.rate_cnt + 24'h00_0001);
      end
      if (rate_hit && s.rate_pend) begin
        // A pending rate only takes over after the error just made
        next_s.cur_rate  = s.new_rate;
        next_s.rate_pend = 1'b0;
      end
      if (s.single_pend) begin
        next_s.single_pend = 1'b0;
      end
    end
    // Several edges before the next opportunity collapse to one
    if (single_trig && !s.single_trig_d &&
        s.error_insert_control[EIC_SINGLE_ENABLE]) begin
      next_s.single_pend = 1'b1;
    end

    // Receive: sync state machine and error checking
    case (s.rx_state)
      BPE_RX_HUNT: begin
        if (rx_valid) begin
          next_s.match_cnt = rx_match ? 6'(s.match_cnt + 6'h01) : 6'h00;
          if (rx_match && s.match_cnt == 6'(SYNC_MATCHES - 6'h01)) begin
            next_s.rx_state  = BPE_RX_SYNC;
            next_s.win_cnt   = 6'h00;
            next_s.win_err   = 3'h0;
          end
        end
      end
      BPE_RX_SYNC: begin
        if (rx_valid) begin
          bit_error      = !rx_match;
          win_sum        = 3'(s.win_err + {2'b00, bit_error});
          next_s.win_cnt = 6'(s.win_cnt + 6'h01);
          next_s.win_err = (s.win_cnt == WINDOW_LAST) ? 3'h0 : win_sum;
          if (bit_error) begin
            next_s.err_cnt = sat_inc(s.err_cnt);
          end
          if (win_sum >= RESYNC_ERRORS && !s.control[CTL_AUTO_DISABLE]) begin
            next_s.rx_state  = BPE_RX_HUNT;
            next_s.match_cnt = 6'h00;
          end
        end
      end
      default: begin
        next_s.rx_state = BPE_RX_HUNT;
      end
    endcase
    // New pattern or manual resync drops the receiver out of sync
    if (rx_load_go || (s.control[CTL_MAN_RESYNC] && !s.resync_d)) begin
      next_s.rx_state  = BPE_RX_HUNT;
      next_s.match_cnt = 6'h00;
    end

    // Counter update: snapshot count, restart at 0 or 1
    update_trig = s.control[CTL_UPDATE_MODE] ?
                  s.eu_s2 : s.control[CTL_LOCAL_UPDATE];
    next_s.update_trig_d = update_trig;
    if (update_trig && !s.update_trig_d) begin
      next_s.reported_cnt  = s.err_cnt;
      next_s.err_cnt       = {23'h00_0000, bit_error};
      next_s.update_status = 1'b1;
    end
    if (!update_trig) begin
      next_s.update_status = 1'b0;
    end

    // Latched events; a new event wins over a read clear
    events[ST_UPDATE]    = next_s.update_status && !s.update_status;
    events[ST_BIT_ERROR] = bit_error;
    events[ST_COUNT_NZ]  = (next_s.reported_cnt != 24'h00_0000) &&
                           (s.reported_cnt == 24'h00_0000);
    events[ST_OOS]       = (next_s.rx_state != s.rx_state);
    next_s.latched = ((rd_go && idx == IDX_LATCHED) ? 4'h0 : s.latched) | events;

    // Register writes at the completing edge
    if (wr_go) begin
      case (idx)
        IDX_CONTROL: next_s.control = pwdata[7:0];
        IDX_PAT_CFG: next_s.pat_cfg = pwdata[7:0] & PCFG_MASK;
        IDX_TAP_CFG: next_s.tap_cfg = pwdata[7:0] & TAP_MASK;
        IDX_SEED0:   next_s.seed_pattern[7:0]   = pwdata[7:0];
        IDX_SEED1:   next_s.seed_pattern[15:8]  = pwdata[7:0];
        IDX_SEED2:   next_s.seed_pattern[23:16] = pwdata[7:0];
        IDX_SEED3:   next_s.seed_pattern[31:24] = pwdata[7:0];
        IDX_EIC: begin
          next_s.error_insert_control = pwdata[7:0] & EIC_MASK;
          if (next_s.cur_rate == 3'h0) begin
            if (wr_rate != 3'h0) begin
              next_s.cur_rate  = wr_rate;
              next_s.rate_cnt  = 24'h00_0000;
              next_s.rate_pend = 1'b0;
            end
          end else begin
            next_s.new_rate  = wr_rate;
            next_s.rate_pend = 1'b1;
          end
        end
        default: begin
          next_s.control = next_s.control;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s          <= '0;
      s.rx_state <= BPE_RX_HUNT;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from flops, except out_of_sync decoded from rx_state
  assign prdata      = s.prdata;
  assign pready      = s.pready;
  assign pslverr     = s.pslverr;
  assign tx_data     = s.tx_data;
  assign out_of_sync = (s.rx_state == BPE_RX_HUNT);

endmodule // bpe_bert

// ---- bpe_bert_chk.sv ----
/*
  Port checker for bpe_bert: bus timing, refusals, transmit hold, sync.
  Assumes it is bound to bpe_bert, one pclk domain.
*/
`timescale 1ns/1ps
module bpe_bert_chk (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Streams and pins
  input wire logic        tx_enable,
  input wire logic        tx_data,
  input wire logic        rx_valid,
  input wire logic        rx_data,
  input wire logic        out_of_sync,
  input wire logic        manual_insert_input,
  input wire logic        external_update_signal
);
  logic [5:0] hunt_cnt;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Bits seen while hunting; saturates so a long hunt cannot wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hunt_cnt <= 6'h00;
    else if (!out_of_sync) hunt_cnt <= 6'h00;
    else if (rx_valid && hunt_cnt != 6'h3f) hunt_cnt <= hunt_cnt + 6'h01;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  property p_wait_state; s_setup ##1 s_access |-> !pready ##1 pready; endproperty
  property p_pulse; pready |=> !pready; endproperty
  property p_refuse;
    pready && (paddr[1:0] != 2'h0 || paddr[7:2] == 6'h01) |-> pslverr;
  endproperty
  property p_refuse_data; pready && pslverr && !pwrite |-> prdata == 32'h0000_0000; endproperty
  property p_upper; pready && !pwrite |-> prdata[31:8] == 24'h00_0000; endproperty
  property p_tx_hold; !tx_enable |=> $stable(tx_data); endproperty
  property p_sync_count; $fell(out_of_sync) |-> hunt_cnt >= 6'h20; endproperty
  property p_sync_valid; $fell(out_of_sync) |-> $past(rx_valid); endproperty
  a_wait_state: assert property (p_wait_state) else $error("pready not after one wait");
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  a_refuse: assert property (p_refuse) else $error("bad address not refused");
  a_refuse_data: assert property (p_refuse_data) else $error("refused read data not zero");
  a_upper: assert property (p_upper) else $error("read data upper bits set");
  a_tx_hold: assert property (p_tx_hold) else $error("tx bit moved without slot");
  a_sync_count: assert property (p_sync_count) else $error("sync too early");
  a_sync_valid: assert property (p_sync_valid) else $error("sync without bit");
endmodule // bpe_bert_chk

// ---- bpe_line_model.sv ----
/*
  Line partner: offers transmit slots and loops each bit into the receiver.
  Assumes the bench drives run and slow just after clock edges.
*/
`timescale 1ns/1ps
module bpe_line_model (
  // Clock, reset and control
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  input  wire logic slow,
  // Line side
  input  wire logic tx_data,
  output logic      tx_enable,
  output logic      rx_valid,
  output logic      rx_data
);
  logic gap;
  // Slow mode skips every other slot to stretch the stream
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap      <= 1'b0;
      rx_valid <= 1'b0;
    end else begin
      gap      <= slow & ~gap;
      rx_valid <= tx_enable;
    end
  end
  assign tx_enable = run & ~gap;
  // Idle line shows the inverse so a stale bit cannot match
  assign rx_data = rx_valid ? tx_data : ~tx_data;
endmodule // bpe_line_model

// ---- bpe_bert_bench.sv ----
/*
  Bench for bpe_bert: APB master, loopback partner, checker bind.
  Assumes bpe_pkg, bpe_line_model and bpe_bert_chk are compiled first.
*/
`timescale 1ns/1ps
module bpe_bert_bench;
  import bpe_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        tx_enable, tx_data, rx_valid, rx_data, out_of_sync, run, slow;
  logic        manual_insert_input, external_update_signal;
  logic [7:0]  paddr, eic_prev;
  logic [31:0] pwdata, prdata, rdv, seed, rnd;
  integer      error_cnt, check_count, seed_var, pos, next_err, pend, single;
  bpe_bert u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .tx_enable, .tx_data, .rx_valid, .rx_data, .out_of_sync,
    .manual_insert_input, .external_update_signal);
  bpe_line_model u_line (.pclk, .presetn, .run, .slow, .tx_data, .tx_enable, .rx_valid,
    .rx_data);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= {idx, 2'h0};
    pwdata <= {24'h00_0000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog may end this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input logic exp_err);
    apb(1'b0, idx, 8'h00);
    check("read data", rdv, {24'h00_0000, exp});
    check("slave error", {31'h0, err}, {31'h0, exp_err});
  endtask
  // Insertion control write; the rate switch waits for the next error
  task automatic eic(input logic [7:0] v);
    apb(1'b1, IDX_EIC, v);
    pend = (v[5:3] == 3'h0) ? 0 : 10 ** v[5:3];
    if (next_err == 0) next_err = pend;
    if (v[2] && !v[0] && v[1] && !eic_prev[1]) single = 1;
    eic_prev = v;
  endtask
  // Run n transmit slots, each bit checked against the expected stream
  task automatic stream(input integer n);
    logic e;
    rnd = $random(seed_var);
    slow <= rnd[0];
    run  <= 1'b1;
    repeat (n) begin
      do @(posedge pclk); while (tx_enable !== 1'b1);
      e = single != 0;
      single = 0;
      if (next_err > 0) begin
        next_err--;
        if (next_err == 0) begin
          e = 1'b1;
          next_err = pend;
        end
      end
      #1 check("tx bit", {31'h0, tx_data}, {31'h0, seed[31 - (pos % 32)] ^ e});
      pos++;
    end
    run  <= 1'b0;
    slow <= 1'b0;
  endtask
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    #(40 * 20000);
    error_cnt++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, run, slow, manual_insert_input, external_update_signal} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    presetn = 1'b0;
    {error_cnt, check_count, pos, next_err, pend, single} = '0;
    seed_var = 82889;
    eic_prev = 8'h00;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(IDX_SEED3, 8'h00, 1'b0);
    rd(IDX_EIC, 8'h00, 1'b0);
    rd(IDX_STATUS, 8'h01, 1'b0);
    rd(IDX_LATCHED, 8'h00, 1'b0);
    rd(6'h01, 8'h00, 1'b1);
    seed = $random(seed_var);
    for (int i = 0; i < 4; i++) apb(1'b1, IDX_SEED0 + 6'(i), seed[8*i +: 8]);
    rd(IDX_SEED3, seed[31:24], 1'b0);
    rnd = $random(seed_var);
    apb(1'b1, IDX_TAP_CFG, {3'h0, rnd[4:0]});
    apb(1'b1, IDX_PAT_CFG, 8'h3f);
    apb(1'b1, IDX_CONTROL, 8'h22);
    stream(64);
    check("sync flag", {31'h0, out_of_sync}, 32'h0000_0000);
    eic(8'h08);
    stream(40);
    eic(8'h10);
    stream(60);
    eic(8'h00);
    stream(110);
    eic(8'h02);
    eic(8'h04);
    eic(8'h06);
    eic(8'h04);
    eic(8'h06);
    stream(20);
    eic(8'h04);
    eic(8'h05);
    manual_insert_input <= 1'b1;
    repeat (6) @(posedge pclk);
    manual_insert_input <= 1'b0;
    repeat (4) @(posedge pclk);
    single = 1;
    stream(20);
    apb(1'b1, IDX_CONTROL, 8'h62);
    rd(IDX_STATUS, 8'h0a, 1'b0);
    rd(IDX_COUNT0, 8'h08, 1'b0);
    rd(IDX_LATCHED, 8'h0f, 1'b0);
    rd(IDX_LATCHED, 8'h00, 1'b0);
    apb(1'b1, IDX_CONTROL, 8'h22);
    rd(IDX_STATUS, 8'h02, 1'b0);
    give_verdict();
  end
endmodule // bpe_bert_bench
bind bpe_bert bpe_bert_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .tx_enable, .tx_data, .rx_valid, .rx_data,
  .out_of_sync, .manual_insert_input, .external_update_signal);
